// ---- pac_top.sv ----
// four-channel process alarm comparator with ahb-lite register slave
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// R1: four channels, each with own alarm type
// R2: output from type, value, hysteresis, standby
// R3: control outputs 1/2 may carry any alarm
// R4: loop break type only on channel 1
// R5: no loop break on position-proportional variant
// R6: type 1 alarms outside set point band
// R7: type 2 (default) alarms at pv>=sp+x
// R8: type 3 alarms at pv<=sp-x
// R9: type 4 alarms inside set point band
// R10: type 5 is type 1 plus standby
// R11: type 6 is type 2 plus standby
// R12: type 7 is type 3 plus standby
// R13: type 8 alarms when pv above x
// R14: type 9 alarms when pv below x
// R15: type 0 holds the output off
// R16: standby suppresses until pv first leaves region
module pac_top
  import pac_pkg::*;
#(
  parameter int unsigned NUM_CH = PAC_NUM_CH
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [3:0]  alarm_out,
  output logic             ctrl_out1,
  output logic             ctrl_out2,
  output logic             irq
);
  // only the four-channel build is served by the fixed per-channel logic below
  if (NUM_CH != PAC_NUM_CH) begin : g_bad_ch
    $error("pac_top supports exactly four channels");
  end

  typedef logic signed [PAC_VAL_W-1:0] pac_val_t;

  // configuration registers
  logic [2:0]           ctrl_q, ctrl_d;
  pac_val_t             pv_q, pv_d, sp_q, sp_d;
  logic [7:0]           sel_q, sel_d;
  logic [3:0]           typ_q [4];
  logic [3:0]           typ_d [4];
  pac_val_t             hi_q [4];
  pac_val_t             hi_d [4];
  pac_val_t             lo_q [4];
  pac_val_t             lo_d [4];
  pac_val_t             hys_q [4];
  pac_val_t             hys_d [4];
  logic [3:0]           irq_q, irq_d, mask_q, mask_d;
  // bus data phase state
  logic                 wr_q, wr_d, rd_q, rd_d;
  logic [7:0]           addr_q, addr_d;
  logic [31:0]          rdata_q, rdata_d;
  // alarm state
  // armed_q marks channels whose standby wait is over
  logic [3:0]           alm_q, alm_d, armed_q, armed_d;
  logic                 o1_q, o1_d, o2_q, o2_d, irqo_q, irqo_d;

  logic                 acc;
  logic [31:0]          rmux;
  logic [3:0]           cond;
  // raw results and standby flags, one bit driven from each channel block
  wire        [3:0]     raw, sb;

  // a transfer is taken only while the bus is ready; idle slots are ignored
  assign acc = hsel & hready & htrans[1];

  // one-cycle address capture, zero wait states
  always_comb begin
    wr_d   = acc & hwrite;
    rd_d   = acc & ~hwrite;
    addr_d = acc ? haddr[7:0] : addr_q;
  end

  // read mux over next-state values, registered at the address phase: hrdata comes
  // from a flop, yet a write landing at that same edge is already visible;
  // unmapped addresses read zero
  always_comb begin
    rmux = 32'h0000_0000;
    unique case (addr_d)
      PAC_OFF_CTRL:   rmux = {29'h0, ctrl_d};
      PAC_OFF_PV:     rmux = {16'h0, pv_d};
      PAC_OFF_SP:     rmux = {16'h0, sp_d};
      PAC_OFF_OUTSEL: rmux = {24'h0, sel_d};
      PAC_OFF_STAT:   rmux = {24'h0, armed_d, alm_d};
      PAC_OFF_IRQ:    rmux = {28'h0, irq_d};
      PAC_OFF_MASK:   rmux = {28'h0, mask_d};
      default: begin
        for (int i = 0; i < 4; i++) begin
          if (addr_d == PAC_OFF_TYPE0 + 8'(4*i)) rmux = {28'h0, typ_d[i]};
          if (addr_d == PAC_OFF_HI0 + 8'(4*i)) rmux = {16'h0, hi_d[i]};
          if (addr_d == PAC_OFF_LO0 + 8'(4*i)) rmux = {16'h0, lo_d[i]};
          if (addr_d == PAC_OFF_HYS0 + 8'(4*i)) rmux = {16'h0, hys_d[i]};
        end
      end
    endcase
    // the word stands through the data phase and is held until the next read
    rdata_d = rd_d ? rmux : rdata_q;
  end

  // register writes; an illegal type code is refused and the old type kept
  always_comb begin
    logic [3:0] nt;
    nt     = 4'h0;
    ctrl_d = ctrl_q;
    pv_d   = pv_q;
    sp_d   = sp_q;
    sel_d  = sel_q;
    mask_d = mask_q;
    typ_d  = typ_q;
    hi_d   = hi_q;
    lo_d   = lo_q;
    hys_d  = hys_q;
    // writes land at the end of the data phase, while hwdata stands;
    // only the low bits of each word are stored, upper bits are ignored
    if (wr_q) begin
      unique case (addr_q)
        PAC_OFF_CTRL:   ctrl_d = hwdata[2:0];
        PAC_OFF_PV:     pv_d   = hwdata[15:0];
        PAC_OFF_SP:     sp_d   = hwdata[15:0];
        PAC_OFF_OUTSEL: sel_d  = hwdata[7:0];
        PAC_OFF_MASK:   mask_d = hwdata[3:0];
        default: begin
          for (int i = 0; i < 4; i++) begin
            nt = hwdata[3:0];
            if (addr_q == PAC_OFF_TYPE0 + 8'(4*i)) begin
              // loop break: channel 1 only, never on position-proportional
              if (nt == PAC_T_LOOP_BRK && (i != 0 || ctrl_q[PAC_CTRL_POS_BIT])) begin // [R4] [R5]
                typ_d[i] = typ_q[i];
              end else if (nt > PAC_T_LOOP_BRK) begin
                typ_d[i] = typ_q[i];
              end else begin
                typ_d[i] = nt; // [R1]
              end
            end
            if (addr_q == PAC_OFF_HI0 + 8'(4*i)) hi_d[i] = hwdata[15:0];
            if (addr_q == PAC_OFF_LO0 + 8'(4*i)) lo_d[i] = hwdata[15:0];
            if (addr_q == PAC_OFF_HYS0 + 8'(4*i)) hys_d[i] = hwdata[15:0];
          end
        end
      endcase
    end
  end

  // per-channel comparison; hysteresis widens the off-going threshold except for band-in (type 4)
  generate
    for (genvar c = 0; c < 4; c++) begin : g_ch
      // 18-bit signed copies so that set point plus deviation cannot wrap
      logic signed [17:0] pv, sp, hi, lo, h;
      logic signed [17:0] hon, hoff, lon, loff;
      logic               up, dn, ab_hi, ab_lo, was;
      logic               raw_c, sb_c;
      always_comb begin
        pv  = 18'(pv_q);
        sp  = 18'(sp_q);
        hi  = 18'(hi_q[c]);
        lo  = 18'(lo_q[c]);
        h   = 18'(hys_q[c]);
        was = alm_q[c];
        // deviation thresholds relative to set point
        hon   = sp + hi;
        lon   = sp - lo;
        hoff  = hon - h;
        loff  = lon + h;
        up    = was ? (pv > hoff) : (pv >= hon); // [R2]
        dn    = was ? (pv < loff) : (pv <= lon);
        ab_hi = was ? (pv > hi - h) : (pv > hi);
        ab_lo = was ? (pv < hi + h) : (pv < hi);
        raw_c = 1'b0;
        sb_c  = 1'b0;
        // type 12 is accepted on channel 1 but has no evaluation here, so it stays quiet
        unique case (typ_q[c])
          PAC_T_OFF:      raw_c = 1'b0; // [R15]
          PAC_T_BAND_OUT: raw_c = up | dn; // [R6]
          PAC_T_DEV_HI:   raw_c = up; // [R7]
          PAC_T_DEV_LO:   raw_c = dn; // [R8]
          PAC_T_BAND_IN:  raw_c = (pv < hon) & (pv > lon); // [R9]
          PAC_T_BAND_SB: begin
            raw_c = up | dn; // [R10]
            sb_c  = 1'b1;
          end
          PAC_T_HI_SB: begin
            raw_c = up; // [R11]
            sb_c  = 1'b1;
          end
          PAC_T_LO_SB: begin
            raw_c = dn; // [R12]
            sb_c  = 1'b1;
          end
          PAC_T_ABS_HI:   raw_c = ab_hi; // [R13]
          PAC_T_ABS_LO:   raw_c = ab_lo; // [R14]
          PAC_T_ABSH_SB: begin
            raw_c = ab_hi;
            sb_c  = 1'b1;
          end
          PAC_T_ABSL_SB: begin
            raw_c = ab_lo;
            sb_c  = 1'b1;
          end
          default:        raw_c = 1'b0; // loop break is not evaluated anywhere; it stays low
        endcase
      end
      assign raw[c] = raw_c;
      assign sb[c]  = sb_c;
    end
  endgenerate

  // standby: armed once pv seen outside alarm region; run low or restart bit rearms
  always_comb begin
    armed_d = armed_q;
    // restart keeps every channel disarmed for as long as the bit stays set
    for (int i = 0; i < 4; i++) begin
      if (!ctrl_q[PAC_CTRL_RUN_BIT] || ctrl_q[PAC_CTRL_RST_BIT]) armed_d[i] = 1'b0;
      else if (!raw[i]) armed_d[i] = 1'b1; // [R16]
    end
    cond  = raw & (~sb | armed_q); // [R16]
    alm_d = ctrl_q[PAC_CTRL_RUN_BIT] ? cond : 4'h0;
  end

  // control output routing and sticky interrupt status; a new event beats the clear
  always_comb begin
    // a disabled route forces its control output low
    o1_d  = sel_q[PAC_SEL_OUT1_LSB+2] & alm_q[sel_q[PAC_SEL_OUT1_LSB +: 2]]; // [R3]
    o2_d  = sel_q[PAC_SEL_OUT2_LSB+2] & alm_q[sel_q[PAC_SEL_OUT2_LSB +: 2]]; // [R3]
    irq_d = irq_q;
    // the clear is applied first so that an edge in the same cycle survives it
    if (wr_q && addr_q == PAC_OFF_IRQ) irq_d = irq_q & ~hwdata[3:0];
    irq_d  = irq_d | (alm_d & ~alm_q);
    irqo_d = |(irq_q & mask_q);
  end

  // one register bank for all state; the reset branch loads constants only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q  <= 3'h0;
      pv_q    <= PAC_VAL_RST;
      sp_q    <= PAC_VAL_RST;
      sel_q   <= PAC_SEL_RST;
      mask_q  <= 4'h0;
      irq_q   <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        typ_q[i] <= PAC_TYPE_RST;
        hi_q[i]  <= PAC_VAL_RST;
        lo_q[i]  <= PAC_VAL_RST;
        hys_q[i] <= PAC_VAL_RST;
      end
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      addr_q  <= 8'h00;
      rdata_q <= 32'h0000_0000;
      alm_q   <= 4'h0;
      armed_q <= 4'h0;
      o1_q    <= 1'b0;
      o2_q    <= 1'b0;
      irqo_q  <= 1'b0;
    end else begin
      ctrl_q  <= ctrl_d;
      pv_q    <= pv_d;
      sp_q    <= sp_d;
      sel_q   <= sel_d;
      mask_q  <= mask_d;
      irq_q   <= irq_d;
      typ_q   <= typ_d;
      hi_q    <= hi_d;
      lo_q    <= lo_d;
      hys_q   <= hys_d;
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      addr_q  <= addr_d;
      rdata_q <= rdata_d;
      alm_q   <= alm_d;
      armed_q <= armed_d;
      o1_q    <= o1_d;
      o2_q    <= o2_d;
      irqo_q  <= irqo_d;
    end
  end

  // outputs come from flops; ready and response are tied, the slave never waits
  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign alarm_out = alm_q;
  assign ctrl_out1 = o1_q;
  assign ctrl_out2 = o2_q;
  assign irq       = irqo_q;
endmodule

`default_nettype wire

// ---- pac_pkg.sv ----
// package for the process alarm comparator: offsets, field layouts, reset values, type codes
package pac_pkg;
  localparam int unsigned PAC_NUM_CH   = 4;
  localparam int unsigned PAC_VAL_W    = 16;
  localparam int unsigned PAC_TYPE_W   = 4;
  // register byte offsets
  localparam logic [7:0] PAC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] PAC_OFF_PV     = 8'h04;
  localparam logic [7:0] PAC_OFF_SP     = 8'h08;
  localparam logic [7:0] PAC_OFF_OUTSEL = 8'h0C;
  localparam logic [7:0] PAC_OFF_STAT   = 8'h10;
  localparam logic [7:0] PAC_OFF_IRQ    = 8'h14;
  localparam logic [7:0] PAC_OFF_MASK   = 8'h18;
  localparam logic [7:0] PAC_OFF_TYPE0  = 8'h20;
  localparam logic [7:0] PAC_OFF_HI0    = 8'h30;
  localparam logic [7:0] PAC_OFF_LO0    = 8'h40;
  localparam logic [7:0] PAC_OFF_HYS0   = 8'h50;
  // control field positions
  localparam int unsigned PAC_CTRL_RUN_BIT = 0;
  localparam int unsigned PAC_CTRL_POS_BIT = 1;
  localparam int unsigned PAC_CTRL_RST_BIT = 2;
  // output select fields: [2] enable, [1:0] channel; out1 at 0, out2 at 4
  localparam int unsigned PAC_SEL_OUT1_LSB = 0;
  localparam int unsigned PAC_SEL_OUT2_LSB = 4;
  // alarm type codes
  localparam logic [3:0] PAC_T_OFF      = 4'h0;
  localparam logic [3:0] PAC_T_BAND_OUT = 4'h1;
  localparam logic [3:0] PAC_T_DEV_HI   = 4'h2;
  localparam logic [3:0] PAC_T_DEV_LO   = 4'h3;
  localparam logic [3:0] PAC_T_BAND_IN  = 4'h4;
  localparam logic [3:0] PAC_T_BAND_SB  = 4'h5;
  localparam logic [3:0] PAC_T_HI_SB    = 4'h6;
  localparam logic [3:0] PAC_T_LO_SB    = 4'h7;
  localparam logic [3:0] PAC_T_ABS_HI   = 4'h8;
  localparam logic [3:0] PAC_T_ABS_LO   = 4'h9;
  localparam logic [3:0] PAC_T_ABSH_SB  = 4'hA;
  localparam logic [3:0] PAC_T_ABSL_SB  = 4'hB;
  localparam logic [3:0] PAC_T_LOOP_BRK = 4'hC;
  // reset values
  localparam logic [3:0]  PAC_TYPE_RST  = PAC_T_DEV_HI;
  localparam logic [15:0] PAC_VAL_RST   = 16'h0000;
  localparam logic [7:0]  PAC_SEL_RST   = 8'h00;
endpackage

// ---- pac_relay_model.sv ----
// alarm output driver model: relays latch the routed alarm levels
`timescale 1ns/100ps
`default_nettype none
module pac_relay_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [3:0] alarm_out,
  input  wire logic       ctrl_out1,
  input  wire logic       ctrl_out2,
  output logic      [5:0] relay
);
  // coils follow their drivers one sample late and drop out on reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      relay <= 6'h00;
    end else begin
      relay <= {ctrl_out2, ctrl_out1, alarm_out};
    end
  end
endmodule
`default_nettype wire

// ---- pac_props.sv ----
// port-level checker for the process alarm comparator
`timescale 1ns/100ps
`default_nettype none
module pac_chk
  import pac_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [3:0]  alarm_out,
  input wire logic        ctrl_out1,
  input wire logic        ctrl_out2,
  input wire logic        irq
);
  logic       wr_q, run_q;
  logic [7:0] wa_q;
  logic [6:0] sel_q;
  logic [3:0] mask_q;
  // shadow of run, mask and routing, taken from bus writes at the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'h0;
      wa_q   <= 8'h00;
      run_q  <= 1'h0;
      sel_q  <= 7'h00;
      mask_q <= 4'h0;
    end else begin
      wr_q <= hsel && hready && htrans[1] && hwrite;
      wa_q <= haddr[7:0];
      if (wr_q && wa_q == PAC_OFF_CTRL) run_q <= hwdata[0];
      if (wr_q && wa_q == PAC_OFF_OUTSEL) sel_q <= hwdata[6:0];
      if (wr_q && wa_q == PAC_OFF_MASK) mask_q <= hwdata[3:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not zero-wait okay");
  unmapped_zero_a: assert property (hsel && hready && htrans[1] && !hwrite && haddr[7:0] >= 8'h60
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  type_range_a: assert property (hsel && hready && htrans[1] && !hwrite
    && haddr[7:0] inside {8'h24, 8'h28, 8'h2C} |=> hrdata[3:0] < PAC_T_LOOP_BRK)
    else $error("loop break type held on a later channel");
  stat_match_a: assert property (hsel && hready && htrans[1] && !hwrite && haddr[7:0] == PAC_OFF_STAT
    ##1 $stable(alarm_out) |-> hrdata[3:0] == alarm_out) else $error("status differs from alarms");
  run_off_a: assert property (!run_q && !$past(run_q) |-> alarm_out == 4'h0)
    else $error("alarm while stopped");
  mask_off_a: assert property (mask_q == 4'h0 [*3] |-> !irq) else $error("irq with all masked");
  out1_route_a: assert property ($stable(sel_q)
    |-> ctrl_out1 == (sel_q[2] & $past(alarm_out[sel_q[1:0]]))) else $error("output 1 misrouted");
  out2_route_a: assert property ($stable(sel_q)
    |-> ctrl_out2 == (sel_q[6] & $past(alarm_out[sel_q[5:4]]))) else $error("output 2 misrouted");
endmodule
bind pac_top pac_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .alarm_out, .ctrl_out1, .ctrl_out2, .irq);
`default_nettype wire

// ---- process_alarm_comparator_bench.sv ----
// self-checking bench for the process alarm comparator
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module process_alarm_comparator_bench;
  import pac_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, ctrl_out1, ctrl_out2, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  alarm_out;
  logic [5:0]  relay;
  wire logic   hready;
  int          fails, n_checks;
  assign hready = hreadyout;  // single slave: its ready is the bus ready
  pac_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
               .hrdata, .hreadyout, .hresp, .alarm_out, .ctrl_out1, .ctrl_out2, .irq);
  pac_relay_model u_relay (.hclk, .hresetn, .alarm_out, .ctrl_out1, .ctrl_out2, .relay);
  initial begin
    hclk = 1'h0;
    forever #25 hclk = ~hclk;
  end
  // one word transfer; each phase is held until ready is seen at an edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'h1;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    rd = hrdata;
  endtask
  // write, then wait out the alarm, status and irq stages
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
    repeat (4) @(posedge hclk);
  endtask
  task chan(input int c, input logic [3:0] t, input logic [31:0] hi, input logic [31:0] lo);
    wr(PAC_OFF_TYPE0 + 8'(4 * c), {28'h0, t});
    wr(PAC_OFF_HI0 + 8'(4 * c), hi);
    wr(PAC_OFF_LO0 + 8'(4 * c), lo);
  endtask
  task pvchk(input logic [31:0] p, input logic [3:0] e);
    wr(PAC_OFF_PV, p);
    `CHK("alarms", e, alarm_out)
  endtask
  task t_reset;
    xfer(1'h0, PAC_OFF_TYPE0, 32'h0);
    `CHK("type reset", {28'h0, PAC_TYPE_RST}, rd)
    xfer(1'h0, 8'hFC, 32'h0);
    `CHK("unmapped", 32'h0, rd)
  endtask
  // set point 100; boundary values test the "or more" edges
  task t_types;
    wr(PAC_OFF_CTRL, 32'h1);
    wr(PAC_OFF_SP, 32'h64);
    chan(0, PAC_T_DEV_HI, 32'hA, 32'h0);
    chan(1, PAC_T_DEV_LO, 32'h0, 32'hA);
    chan(2, PAC_T_BAND_OUT, 32'h5, 32'h5);
    chan(3, PAC_T_ABS_HI, 32'h32, 32'h0);
    pvchk(32'h6E, 4'hD);
    pvchk(32'h6D, 4'hC);
    pvchk(32'h5A, 4'hE);
    pvchk(32'h64, 4'h8);
    xfer(1'h0, PAC_OFF_STAT, 32'h0);
    `CHK("status", 4'h8, rd[3:0])
  endtask
  task t_more;
    wr(PAC_OFF_TYPE0, {28'h0, PAC_T_OFF});
    chan(2, PAC_T_BAND_IN, 32'h5, 32'h5);
    chan(3, PAC_T_ABS_LO, 32'h32, 32'h0);
    pvchk(32'h64, 4'h4);
    pvchk(32'h28, 4'hA);
    pvchk(32'hC8, 4'h0);
  endtask
  task t_refuse;
    wr(PAC_OFF_TYPE0 + 8'h4, 32'hC);
    xfer(1'h0, PAC_OFF_TYPE0 + 8'h4, 32'h0);
    `CHK("type ch2", {28'h0, PAC_T_DEV_LO}, rd)
    wr(PAC_OFF_TYPE0, 32'hC);
    xfer(1'h0, PAC_OFF_TYPE0, 32'h0);
    `CHK("type ch1", 32'hC, rd)
    wr(PAC_OFF_CTRL, 32'h3);
    wr(PAC_OFF_TYPE0, {28'h0, PAC_T_DEV_HI});
    wr(PAC_OFF_TYPE0, 32'hC);
    xfer(1'h0, PAC_OFF_TYPE0, 32'h0);
    `CHK("type pos", {28'h0, PAC_T_DEV_HI}, rd)
  endtask
  // stop re-arms standby; starting inside the alarm region must stay quiet
  task t_standby;
    wr(PAC_OFF_TYPE0 + 8'h4, 32'h0);
    wr(PAC_OFF_TYPE0 + 8'h8, 32'h0);
    wr(PAC_OFF_TYPE0 + 8'hC, 32'h0);
    wr(PAC_OFF_CTRL, 32'h0);
    wr(PAC_OFF_TYPE0, {28'h0, PAC_T_HI_SB});
    wr(PAC_OFF_PV, 32'h78);
    wr(PAC_OFF_CTRL, 32'h1);
    `CHK("standby", 4'h0, alarm_out)
    pvchk(32'h64, 4'h0);
    pvchk(32'h78, 4'h1);
  endtask
  task t_route;
    wr(PAC_OFF_OUTSEL, 32'h54);
    `CHK("route a", 7'h23, {relay, ctrl_out1})
    wr(PAC_OFF_OUTSEL, 32'h40);
    `CHK("route b", 2'h2, {ctrl_out2, ctrl_out1})
  endtask
  task t_irq;
    wr(PAC_OFF_IRQ, 32'hF);
    wr(PAC_OFF_MASK, 32'h0);
    pvchk(32'h64, 4'h0);
    pvchk(32'h78, 4'h1);
    `CHK("irq masked", 1'h0, irq)
    xfer(1'h0, PAC_OFF_IRQ, 32'h0);
    `CHK("irq status", 4'h1, rd[3:0])
    wr(PAC_OFF_MASK, 32'h1);
    `CHK("irq raised", 1'h1, irq)
    wr(PAC_OFF_IRQ, 32'h1);
    `CHK("irq cleared", 1'h0, irq)
  endtask
  // hysteresis holds an alarm until pv drops hys below the on point; restart re-arms standby
  task t_hys;
    wr(PAC_OFF_TYPE0, {28'h0, PAC_T_DEV_HI});
    wr(PAC_OFF_HYS0, 32'h5);
    pvchk(32'h6A, 4'h1);
    pvchk(32'h69, 4'h0);
    pvchk(32'h6C, 4'h0);
    wr(PAC_OFF_TYPE0, {28'h0, PAC_T_HI_SB});
    pvchk(32'h78, 4'h1);
    wr(PAC_OFF_CTRL, 32'h5);
    wr(PAC_OFF_CTRL, 32'h1);
    `CHK("restart", 4'h0, alarm_out)
    chan(1, PAC_T_LO_SB, 32'h0, 32'hA);
    chan(2, PAC_T_ABSL_SB, 32'h64, 32'h0);
    chan(3, PAC_T_BAND_SB, 32'h5, 32'h5);
    pvchk(32'h50, 4'hE);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
    fails = 0;
    n_checks = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_reset;
    t_types;
    t_more;
    t_refuse;
    t_standby;
    t_route;
    t_irq;
    t_hys;
    complete_run;
  end
  // the sequence needs well under 1000 cycles; a hang ends here
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    complete_run;
  end
endmodule
`default_nettype wire
